// [hw/nvm_sequencer.sv]
// nvm row and eeprom sequencer: control, address and key registers,
// program flash write latches, data eeprom store and the cycle sequencer.
// assumes the core presents one register or table access per cycle on clk.
//
// Functional notes
// RULE1 - flash erase or program works per 32-word row
// RULE2 - keys 0x55 then 0xaa unlock any operation
// RULE3 - core stalled until flash row erase completes
// RULE4 - flash program end clears go, core stalled
// RULE5 - 96-byte latches load via table low/high writes
// RULE6 - high latch write keeps low eight bits
// RULE7 - software puts two no-ops after go
// RULE8 - software writes 0x4041 to erase a row
// RULE9 - software loads row address before erase
// RULE10 - eeprom sits at 0x7ff000 to 0x7ffffe
// RULE11 - eeprom single word and 16-word block operations
// RULE12 - eeprom cycles never stall the core
// RULE13 - software waits before next eeprom write
// RULE14 - eeprom read during cycle returns unspecified data
// RULE15 - go bit set by software, cleared by hardware
// RULE16 - write permit gates writes, clear after power-up
// RULE17 - reset during write sets abort, keeps address
// RULE18 - completion sets done flag, software clears
// RULE19 - software erases eeprom word before writing
// RULE20 - table read returns eeprom word at address
// RULE21 - unlock key register is write only
// RULE22 - address registers capture table address 23:0
// RULE23 - operation lasts 2 ms, started by go
// RULE24 - go needs permit set by earlier write
// RULE25 - 0xaa must directly follow 0x55 to arm
// RULE26 - address high upper byte reads zero
`timescale 1ns/1ps
module nvm_sequencer #(
    parameter int OP_CYCLES = nvm_pkg::OP_CYCLES,
    parameter int EE_WORDS  = nvm_pkg::EE_WORDS
) (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire nvm_pkg::sfr_req_t    sfr_req,
    output logic [15:0]               sfr_rdata,
    input  wire nvm_pkg::tbl_req_t    tbl_req,
    output logic [15:0]               tbl_rdata,
    output logic                      cpu_stall,
    output logic                      memory_op_done_flag,
    input  wire logic                 done_flag_clear,
    input  wire logic                 external_master_reset,
    input  wire logic                 watchdog_timer_reset,
    output logic                      flash_erase,
    output logic                      flash_program,
    output logic [17:0]               flash_row,
    input  wire logic [4:0]           flash_latch_index,
    output logic [23:0]               flash_latch_data
);
    localparam int IW = $clog2(EE_WORDS);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic in_eeprom(input logic [23:0] a);
        return (a >= nvm_pkg::EE_FIRST) && (a <= nvm_pkg::EE_LAST); // [RULE10]
    endfunction : in_eeprom

    logic [15:0]         control_reg;
    logic [15:0]         addr_low_reg;
    logic [7:0]          addr_high_reg;
    logic                key_first_reg;
    logic                unlocked_reg;
    logic                stall_reg;
    logic                done_flag_reg;
    logic [15:0]         sfr_rdata_reg;
    logic [15:0]         tbl_rdata_reg;
    logic [6:0]          op_code_reg;
    logic [23:0]         op_addr_reg;
    logic                mreset_sync1_reg;
    logic                mreset_sync2_reg;
    logic                flash_erase_reg;
    logic                flash_program_reg;
    logic [23:0]         flash_latch_data_reg;
    logic [15:0]         row_low_reg [nvm_pkg::ROW_WORDS];
    logic [7:0]          row_high_reg [nvm_pkg::ROW_WORDS];
    logic [15:0]         ee_latch_reg [nvm_pkg::EE_BLOCK_WORDS];
    logic [15:0]         ee_mem [EE_WORDS];
    nvm_pkg::seq_state_t state_reg;
    nvm_pkg::seq_state_t state_next;

    wire         wr_ctl   = sfr_req.wr && (sfr_req.addr == nvm_pkg::CONTROL_OFFSET);
    wire         wr_low   = sfr_req.wr && (sfr_req.addr == nvm_pkg::ADDR_LOW_OFFSET);
    wire         wr_high  = sfr_req.wr && (sfr_req.addr == nvm_pkg::ADDR_HIGH_OFFSET);
    wire         wr_key   = sfr_req.wr && (sfr_req.addr == nvm_pkg::KEY_OFFSET);
    wire         tbl_wr   = tbl_req.wr_low || tbl_req.wr_high;
    wire         tbl_any  = tbl_wr || tbl_req.rd;
    wire         tbl_ee   = in_eeprom(tbl_req.addr);
    wire         any_wr   = sfr_req.wr || tbl_wr;
    wire [23:0]  nvm_addr = {addr_high_reg, addr_low_reg};
    wire [IW-1:0] rd_idx  = tbl_req.addr[IW:1];
    wire [4:0]   row_idx  = tbl_req.addr[nvm_pkg::ROW_IDX_W:1];
    wire [3:0]   blk_idx  = tbl_req.addr[nvm_pkg::EE_BLK_IDX_W:1];

    // ------------------------------------------------------------------
    // operation start, completion and abort
    // ------------------------------------------------------------------
    wire go_req    = wr_ctl && sfr_req.wdata[nvm_pkg::GO_BIT];
    wire start_op  = go_req && unlocked_reg && control_reg[nvm_pkg::PERMIT_BIT]
                     && (state_reg == nvm_pkg::ST_IDLE);      // [RULE2] [RULE24] [RULE16]
    wire reset_hit = mreset_sync2_reg || watchdog_timer_reset;
    wire busy      = (state_reg != nvm_pkg::ST_IDLE);
    wire abort_op  = reset_hit && busy;                        // [RULE17]
    wire timer_done;
    wire op_erase  = op_code_reg[nvm_pkg::OP_ERASE_BIT];
    wire op_multi  = op_code_reg[nvm_pkg::OP_MULTI_BIT];
    wire start_ee  = control_reg[nvm_pkg::OP_EEPROM_BIT];

    nvm_cycle_timer #(
        .CYCLES (OP_CYCLES)
    ) u_timer (
        .clk   (clk),
        .rstn  (rstn),
        .start (start_op),
        .abort (abort_op),
        .busy  (),
        .done  (timer_done)
    );

    // ------------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            nvm_pkg::ST_IDLE: begin
                if (start_op) begin
                    state_next = start_ee ? nvm_pkg::ST_EEPROM : nvm_pkg::ST_FLASH;
                end
            end
            nvm_pkg::ST_FLASH, nvm_pkg::ST_EEPROM: begin
                if (timer_done || abort_op) begin                   // [RULE23]
                    state_next = nvm_pkg::ST_IDLE;
                end
            end
            default: state_next = nvm_pkg::ST_IDLE;
        endcase
    end

    // external master reset arrives from a pin
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mreset_sync1_reg <= 1'b0;
            mreset_sync2_reg <= 1'b0;
        end else begin
            mreset_sync1_reg <= external_master_reset;
            mreset_sync2_reg <= mreset_sync1_reg;
        end
    end

    // state, captured operation and flash strobes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg         <= nvm_pkg::ST_IDLE;
            op_code_reg       <= '0;
            op_addr_reg       <= '0;
            stall_reg         <= 1'b0;
            flash_erase_reg   <= 1'b0;
            flash_program_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (start_op) begin
                op_code_reg <= control_reg[nvm_pkg::OPCODE_MSB:0];
                op_addr_reg <= nvm_addr;
            end
            stall_reg <= (state_next == nvm_pkg::ST_FLASH);              // [RULE3] [RULE4] [RULE12]
            flash_erase_reg   <= (state_next == nvm_pkg::ST_FLASH) &&
                                 (start_op ? control_reg[nvm_pkg::OP_ERASE_BIT] : op_erase);
            flash_program_reg <= (state_next == nvm_pkg::ST_FLASH) &&
                                 !(start_op ? control_reg[nvm_pkg::OP_ERASE_BIT] : op_erase);
        end
    end

    // ------------------------------------------------------------------
    // key sequence: 0xaa must be the very next write after 0x55
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            key_first_reg <= 1'b0;
            unlocked_reg  <= 1'b0;
        end else if (any_wr) begin
            key_first_reg <= wr_key && (sfr_req.wdata[7:0] == nvm_pkg::KEY_FIRST);  // [RULE25]
            unlocked_reg  <= wr_key && key_first_reg &&
                             (sfr_req.wdata[7:0] == nvm_pkg::KEY_SECOND);          // [RULE2]
        end
    end

    // ------------------------------------------------------------------
    // control register: go set-only, abort flag set wins over clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            control_reg <= nvm_pkg::CONTROL_RESET;                   // [RULE16]
        end else begin
            if (wr_ctl) begin
                control_reg[nvm_pkg::PERMIT_BIT]     <= sfr_req.wdata[nvm_pkg::PERMIT_BIT];
                control_reg[nvm_pkg::OPCODE_MSB:0]   <= sfr_req.wdata[nvm_pkg::OPCODE_MSB:0];
            end
            if (start_op) begin
                control_reg[nvm_pkg::GO_BIT] <= 1'b1;                // [RULE15] [RULE23]
            end else if (timer_done || abort_op) begin
                control_reg[nvm_pkg::GO_BIT] <= 1'b0;                // [RULE4] [RULE15]
            end
            if (abort_op) begin
                control_reg[nvm_pkg::ABORT_BIT] <= 1'b1;             // [RULE17]
            end else if (wr_ctl) begin
                control_reg[nvm_pkg::ABORT_BIT] <= sfr_req.wdata[nvm_pkg::ABORT_BIT];
            end
            if (tbl_wr) begin
                control_reg[nvm_pkg::LATCH_BIT] <= 1'b1;
            end else if (timer_done) begin
                control_reg[nvm_pkg::LATCH_BIT] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // address registers, frozen while an operation runs
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_low_reg  <= nvm_pkg::ADDR_RESET;
            addr_high_reg <= '0;
        end else if (!busy) begin
            if (tbl_any) begin
                addr_low_reg  <= tbl_req.addr[15:0];                 // [RULE22]
                addr_high_reg <= tbl_req.addr[23:16];
            end else begin
                if (wr_low) addr_low_reg <= sfr_req.wdata;
                if (wr_high) addr_high_reg <= sfr_req.wdata[7:0];    // [RULE26]
            end
        end
    end

    // ------------------------------------------------------------------
    // done flag: completion sets, software clears, set wins
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done_flag_reg <= 1'b0;
        end else begin
            done_flag_reg <= timer_done || (done_flag_reg && !done_flag_clear); // [RULE18]
        end
    end

    // ------------------------------------------------------------------
    // register and table read data
    // ------------------------------------------------------------------
    wire [15:0] sfr_sel =
        (sfr_req.addr == nvm_pkg::CONTROL_OFFSET)   ? control_reg :
        (sfr_req.addr == nvm_pkg::ADDR_LOW_OFFSET)  ? addr_low_reg :
        (sfr_req.addr == nvm_pkg::ADDR_HIGH_OFFSET) ? {8'h00, addr_high_reg} : // [RULE26]
        16'h0000;                                    // key and unmapped read zero [RULE21]

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata_reg <= '0;
            tbl_rdata_reg <= '0;
        end else begin
            if (sfr_req.rd) sfr_rdata_reg <= sfr_sel;
            if (tbl_req.rd) tbl_rdata_reg <= tbl_ee ? ee_mem[rd_idx] : 16'h0000; // [RULE20] [RULE14]
        end
    end

    // ------------------------------------------------------------------
    // write latches: 32 flash words and 16 eeprom words
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flash_latch_data_reg <= '0;
        end else begin
            flash_latch_data_reg <= {row_high_reg[flash_latch_index],
                                     row_low_reg[flash_latch_index]};       // [RULE1]
        end
    end

    always_ff @(posedge clk) begin
        if (tbl_req.wr_low && !tbl_ee) row_low_reg[row_idx] <= tbl_req.wdata;     // [RULE5]
        if (tbl_req.wr_high && !tbl_ee) row_high_reg[row_idx] <= tbl_req.wdata[7:0]; // [RULE6]
        if (tbl_req.wr_low && tbl_ee) ee_latch_reg[blk_idx] <= tbl_req.wdata;     // [RULE11]
    end

    // ------------------------------------------------------------------
    // eeprom store: word or block commit on completion
    // ------------------------------------------------------------------
    wire [IW-1:0] op_word = op_addr_reg[IW:1];
    wire [IW-1:0] op_base = {op_addr_reg[IW:nvm_pkg::EE_BLK_IDX_W+1], 4'h0};
    wire          ee_commit = timer_done && (state_reg == nvm_pkg::ST_EEPROM);

    logic [IW-1:0] ee_tgt [nvm_pkg::EE_BLOCK_WORDS];
    logic          ee_hit [nvm_pkg::EE_BLOCK_WORDS];

    generate
        for (genvar i = 0; i < nvm_pkg::EE_BLOCK_WORDS; i++) begin : g_ee
            assign ee_tgt[i] = op_multi ? (op_base | IW'(i)) : op_word;   // [RULE11]
            assign ee_hit[i] = op_multi || (op_word[3:0] == 4'(i));
        end
    endgenerate

    // one process owns the store, so each word has a single driver
    always_ff @(posedge clk) begin
        for (int i = 0; i < nvm_pkg::EE_BLOCK_WORDS; i++) begin
            if (ee_commit && ee_hit[i]) begin
                ee_mem[ee_tgt[i]] <= op_erase ? nvm_pkg::ERASED_WORD : ee_latch_reg[i];
            end
        end
    end

    assign sfr_rdata           = sfr_rdata_reg;
    assign tbl_rdata           = tbl_rdata_reg;
    assign cpu_stall           = stall_reg;
    assign memory_op_done_flag = done_flag_reg;
    assign flash_erase         = flash_erase_reg;
    assign flash_program       = flash_program_reg;
    assign flash_row           = op_addr_reg[23:6];                 // [RULE1]
    assign flash_latch_data    = flash_latch_data_reg;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    wire go_bit = control_reg[nvm_pkg::GO_BIT];

    property p_go_needs_key;
        @(posedge clk) disable iff (!rstn)
        $rose(go_bit) |-> $past(unlocked_reg) && $past(control_reg[nvm_pkg::PERMIT_BIT]);
    endproperty
    a_go_needs_key: assert property (p_go_needs_key)  // [RULE2] [RULE24]
        else $error("go set without unlock and permit");

    property p_permit_needed;
        @(posedge clk) disable iff (!rstn)
        go_req && !control_reg[nvm_pkg::PERMIT_BIT] && !go_bit |=> !go_bit;
    endproperty
    a_permit_needed: assert property (p_permit_needed)  // [RULE16]
        else $error("go set while permit clear");

    property p_flash_stall;
        @(posedge clk) disable iff (!rstn)
        (state_reg == nvm_pkg::ST_FLASH) |-> cpu_stall && go_bit;
    endproperty
    a_flash_stall: assert property (p_flash_stall)  // [RULE3]
        else $error("core not stalled during flash cycle");

    property p_flash_end;
        @(posedge clk) disable iff (!rstn)
        timer_done && (state_reg == nvm_pkg::ST_FLASH) |=> !go_bit && !cpu_stall;
    endproperty
    a_flash_end: assert property (p_flash_end)  // [RULE4]
        else $error("go or stall left after flash cycle");

    property p_ee_no_stall;
        @(posedge clk) disable iff (!rstn)
        (state_reg == nvm_pkg::ST_EEPROM) |-> !cpu_stall;
    endproperty
    a_ee_no_stall: assert property (p_ee_no_stall)  // [RULE12]
        else $error("eeprom cycle stalls the core");

    property p_go_hw_clear;
        @(posedge clk) disable iff (!rstn)
        $fell(go_bit) |-> $past(timer_done) || $past(abort_op);
    endproperty
    a_go_hw_clear: assert property (p_go_hw_clear)  // [RULE15]
        else $error("go cleared without completion");

    property p_abort;
        @(posedge clk) disable iff (!rstn)
        abort_op |=> control_reg[nvm_pkg::ABORT_BIT] && !go_bit && $stable(nvm_addr);
    endproperty
    a_abort: assert property (p_abort)  // [RULE17]
        else $error("abort flag or address wrong");

    property p_done_flag;
        @(posedge clk) disable iff (!rstn)
        timer_done |=> memory_op_done_flag ##1 (memory_op_done_flag || $past(done_flag_clear));
    endproperty
    a_done_flag: assert property (p_done_flag)  // [RULE18]
        else $error("done flag missing");

    property p_high_zero;
        @(posedge clk) disable iff (!rstn)
        sfr_req.rd && (sfr_req.addr == nvm_pkg::ADDR_HIGH_OFFSET) |=> sfr_rdata[15:8] == 8'h00;
    endproperty
    a_high_zero: assert property (p_high_zero)  // [RULE26]
        else $error("address high upper byte not zero");

    property p_key_wo;
        @(posedge clk) disable iff (!rstn)
        sfr_req.rd && (sfr_req.addr == nvm_pkg::KEY_OFFSET) |=> sfr_rdata == 16'h0000;
    endproperty
    a_key_wo: assert property (p_key_wo)  // [RULE21]
        else $error("key register readable");

    c_flash_op: cover property (@(posedge clk) disable iff (!rstn)
        $rose(stall_reg) ##[1:1000] $fell(stall_reg));
    c_ee_op: cover property (@(posedge clk) disable iff (!rstn)
        ee_commit);
    c_abort: cover property (@(posedge clk) disable iff (!rstn)
        abort_op);

endmodule : nvm_sequencer

// [inc/nvm_pkg.sv]
// package for the nvm row and eeprom sequencer: register map, control
// fields, address ranges, timing and the request carriers.
// assumes a 200 MHz system clock shared by the core and this block.
package nvm_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_LOW_OFFSET  = 16'h0762;
    localparam logic [15:0] ADDR_HIGH_OFFSET = 16'h0764;
    localparam logic [15:0] CONTROL_OFFSET   = 16'h0920;
    localparam logic [15:0] KEY_OFFSET       = 16'h9920;
    localparam logic [15:0] CONTROL_RESET    = 16'h0000;
    localparam logic [15:0] ADDR_RESET       = 16'h0000;
    localparam logic [7:0]  KEY_FIRST        = 8'h55;
    localparam logic [7:0]  KEY_SECOND       = 8'haa;

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    localparam int GO_BIT         = 15;
    localparam int PERMIT_BIT     = 14;
    localparam int ABORT_BIT      = 13;
    localparam int LATCH_BIT      = 8;
    localparam int OPCODE_MSB     = 6;
    localparam int OP_ERASE_BIT   = 6;
    localparam int OP_EEPROM_BIT  = 2;
    localparam int OP_MULTI_BIT   = 0;
    localparam logic [15:0] CONTROL_WMASK = 16'h607f;

    // ------------------------------------------------------------------
    // memory geometry
    // ------------------------------------------------------------------
    localparam int ROW_WORDS      = 32;
    localparam int ROW_IDX_W      = 5;
    localparam int EE_BLOCK_WORDS = 16;
    localparam int EE_BLK_IDX_W   = 4;
    localparam int EE_WORDS       = 4096;
    localparam logic [23:0] EE_FIRST = 24'h7ff000;
    localparam logic [23:0] EE_LAST  = 24'h7ffffe;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int OP_TIME_US    = 2000;
    localparam int OP_CYCLES     = (OP_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);

    // ------------------------------------------------------------------
    // carriers and states
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic        wr_low;
        logic        wr_high;
        logic        rd;
        logic [23:0] addr;
        logic [15:0] wdata;
    } tbl_req_t;

    typedef enum logic [1:0] {ST_IDLE, ST_FLASH, ST_EEPROM} seq_state_t;

endpackage : nvm_pkg

// [hw/nvm_cycle_timer.sv]
// cycle timer for one erase or program operation.
// assumes start and abort are single-cycle pulses on clk.
`timescale 1ns/1ps
module nvm_cycle_timer #(
    parameter int CYCLES = 400000
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic start,
    input  wire logic abort,
    output logic      busy,
    output logic      done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_reg;
    logic          busy_reg;
    logic          done_reg;
    wire           at_end = busy_reg && (count_reg == LAST);

    // ------------------------------------------------------------------
    // count the operation, abort wins over completion
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            done_reg  <= at_end && !abort;
            count_reg <= (start || !busy_reg) ? '0 : count_reg + 1'b1;
            busy_reg  <= abort ? 1'b0 : (start ? 1'b1 : (at_end ? 1'b0 : busy_reg));
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;

endmodule : nvm_cycle_timer

// [sim/core_model.sv]
// core model: register and table accesses as one-cycle pulses
// assumes nvm_pkg and a bench clock; drives 1 ns after each edge
`timescale 1ns/1ps
module core_model (
    input  wire logic         clk,
    output nvm_pkg::sfr_req_t sfr_req,
    output nvm_pkg::tbl_req_t tbl_req
);
    initial sfr_req = '0;
    initial tbl_req = '0;
    // register access; strobes drop, released address and data show the inverse of the last value
    task automatic sfr(input logic w, input logic [15:0] a, d);
        @(posedge clk) #1 sfr_req = '{w, !w, a, d};
        @(posedge clk) #1 sfr_req = '{1'b0, 1'b0, ~a, ~d};
    endtask : sfr
    // table access, k is {wr_low, wr_high, rd}
    task automatic tbl(input logic [2:0] k, input logic [23:0] a, input logic [15:0] d);
        @(posedge clk) #1 tbl_req = '{k[2], k[1], k[0], a, d};
        @(posedge clk) #1 tbl_req = '{1'b0, 1'b0, 1'b0, ~a, ~d};
    endtask : tbl
    // permit first, keys back to back, then go, then two idle cycles
    task automatic go(input logic [15:0] c);
        sfr(1'b1, nvm_pkg::CONTROL_OFFSET, c);
        sfr(1'b1, nvm_pkg::KEY_OFFSET, 16'h0055);
        sfr(1'b1, nvm_pkg::KEY_OFFSET, 16'h00aa);
        sfr(1'b1, nvm_pkg::CONTROL_OFFSET, c | 16'h8000);
        repeat (2) @(posedge clk);
        #1;
    endtask : go
endmodule : core_model

// [sim/nvm_sequencer_tb.sv]
// testbench for the nvm sequencer with a short operation time
// assumes core_model drives all register and table traffic
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module nvm_sequencer_tb;
    logic              clk = 1'b0, rstn = 1'b0, clr = 1'b0, wdt = 1'b0, emr = 1'b0;
    logic [4:0]        lidx = 5'h1f;
    logic [15:0]       rd, trd;
    logic              stall, done, ers, prg;
    logic [17:0]       row;
    logic [23:0]       lat;
    nvm_pkg::sfr_req_t sreq;
    nvm_pkg::tbl_req_t treq;
    int                fails = 0, checked = 0;
    // rows: address, written value, value read back
    logic [15:0] rows [4][3] = '{'{16'h0762, 16'h1234, 16'h1234},
        '{16'h0764, 16'hffab, 16'h00ab}, '{16'h9920, 16'h0055, 16'h0000},
        '{16'h0920, 16'hc041, 16'h4041}};
    always #2.5 clk = ~clk;
    core_model core_model_inst (.clk(clk), .sfr_req(sreq), .tbl_req(treq));
    nvm_sequencer #(.OP_CYCLES(20)) nvm_sequencer_inst (
        .clk(clk), .rstn(rstn), .sfr_req(sreq), .sfr_rdata(rd), .tbl_req(treq),
        .tbl_rdata(trd), .cpu_stall(stall), .memory_op_done_flag(done),
        .done_flag_clear(clr), .external_master_reset(emr), .watchdog_timer_reset(wdt),
        .flash_erase(ers), .flash_program(prg), .flash_row(row),
        .flash_latch_index(lidx), .flash_latch_data(lat));
    task automatic wr(input logic [15:0] a, d);
        core_model_inst.sfr(1'b1, a, d);
    endtask : wr
    task automatic rr(input logic [15:0] a);
        core_model_inst.sfr(1'b0, a, 16'h0000);
    endtask : rr
    // bounded wait for the done flag, then clear it
    task automatic wait_done;
        int n;
        n = 0;
        while (done !== 1'b1 && n < 100) begin
            @(posedge clk) #1;
            n++;
        end
        if (n == 100) begin
            fails++;
            final_report();
        end
        #1 clr = 1'b1;
        @(posedge clk) #1 clr = 1'b0;
        `CHK(done, 1'b0)
    endtask : wait_done
    task automatic final_report;
        if (fails == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (10) @(posedge clk);
        #1 rstn = 1'b1;
        rr(16'h0920); `CHK(rd, 16'h0000)
        foreach (rows[i]) begin
            wr(rows[i][0], rows[i][1]);
            rr(rows[i][0]); `CHK(rd, rows[i][2])
        end
        // flash row erase stalls the core
        wr(16'h0764, 16'h0000);
        wr(16'h0762, 16'h0040);
        core_model_inst.go(16'h4041); `CHK({stall, ers, row}, {2'b11, 18'h1})
        wait_done(); `CHK(stall, 1'b0)
        rr(16'h0920); `CHK(rd, 16'h4041)
        // latch load, upper byte of high write dropped, then program
        core_model_inst.tbl(3'b100, 24'h000002, 16'hbeef);
        core_model_inst.tbl(3'b010, 24'h000002, 16'h12cd);
        lidx = 5'h01;
        @(posedge clk) #1 `CHK(lat, 24'hcdbeef)
        core_model_inst.go(16'h4001); `CHK({stall, prg}, 2'b11)
        wait_done();
        rr(16'h0920); `CHK(rd, 16'h4001)
        // eeprom word erase, then write without stall, then read back
        core_model_inst.tbl(3'b100, 24'h7ff004, 16'h1234);
        core_model_inst.go(16'h4044);
        wait_done();
        core_model_inst.tbl(3'b001, 24'h7ff004, 16'h0000); `CHK(trd, 16'hffff)
        core_model_inst.go(16'h4004); `CHK(stall, 1'b0)
        wait_done();
        core_model_inst.tbl(3'b001, 24'h7ff004, 16'h0000); `CHK(trd, 16'h1234)
        rr(16'h0762); `CHK(rd, 16'hf004)
        // go without keys, and keys split by another write
        wr(16'h0920, 16'hc004);
        rr(16'h0920); `CHK(rd[15], 1'b0)
        wr(16'h9920, 16'h0055);
        wr(16'h0762, 16'hf004);
        wr(16'h9920, 16'h00aa);
        wr(16'h0920, 16'hc004);
        rr(16'h0920); `CHK(rd[15], 1'b0)
        // watchdog event in mid-write
        core_model_inst.go(16'h4004);
        #1 wdt = 1'b1;
        @(posedge clk) #1 wdt = 1'b0;
        rr(16'h0920); `CHK(rd, 16'h6004)
        rr(16'h0762); `CHK(rd, 16'hf004)
        // pin reset in mid-write, then a full reset clears permit
        core_model_inst.go(16'h4004);
        #1 emr = 1'b1;
        @(posedge clk) #1 emr = 1'b0;
        repeat (2) @(posedge clk);
        rr(16'h0920); `CHK(rd, 16'h6004)
        #1 rstn = 1'b0;
        @(posedge clk) #1 rstn = 1'b1;
        rr(16'h0920); `CHK(rd, 16'h0000)
        final_report();
    end
endmodule : nvm_sequencer_tb
